// File: design/dac_port_host.v
`timescale 1ns/1ps
`include "dac_port_consts.vh"

module dac_port_host (
    // Clock and reset
    input  wire        REF_CLK_I,
    input  wire        RST_N_I,
    // AHB-Lite slave
    input  wire        HSEL_I,
    input  wire [11:0] HADDR_I,
    input  wire [1:0]  HTRANS_I,
    input  wire        HWRITE_I,
    input  wire [2:0]  HSIZE_I,
    input  wire [31:0] HWDATA_I,
    output wire [31:0] HRDATA_O,
    output reg         HREADYOUT_O,
    output reg         HRESP_O,
    // Converter parallel port
    output reg  [11:0] DATA_O,
    output reg         DATA_OE_O,
    input  wire [11:0] DATA_I,
    output reg         CHAN_SEL_LO_O,
    output reg         CHAN_SEL_HI_O,
    output reg         RD_WR_N_O,
    output reg         CHIP_SEL_N_O,
    output reg         OUTPUT_UPDATE_N_O,
    output reg         PRESET_N_O
);

    localparam PH_IDLE   = 2'd0;
    localparam PH_SETUP  = 2'd1;
    localparam PH_STROBE = 2'd2;
    localparam PH_HOLD   = 2'd3;

    wire        wr_en;
    wire [11:0] wr_addr;
    wire [31:0] wr_data;
    wire        rd_req;
    wire [11:0] rd_addr;
    reg  [31:0] rd_data;

    wire [1:0]  phase;
    wire [3:0]  count;
    wire        seq_done;

    reg  [1:0]  chan;
    reg  [2:0]  op;
    reg         variant_zero;
    reg  [11:0] wdata;
    reg  [11:0] rdata;
    reg         busy;
    reg         done;
    reg         bad_op;
    reg         start;

    function op_valid;
        input [2:0] o;
        begin
            op_valid = (o <= `OP_PRESET_LATCH);
        end
    endfunction

    function is_port_op;
        input [2:0] o;
        begin
            is_port_op = (o == `OP_WRITE) || (o == `OP_WRITE_THRU) || (o == `OP_READ);
        end
    endfunction

    ahb_reg_slave u_slave (
        .clk_i     (REF_CLK_I),
        .rst_n_i   (RST_N_I),
        .hsel_i    (HSEL_I),
        .haddr_i   (HADDR_I),
        .htrans_i  (HTRANS_I),
        .hwrite_i  (HWRITE_I),
        .hsize_i   (HSIZE_I),
        .hwdata_i  (HWDATA_I),
        .hrdata_o  (HRDATA_O),
        .wr_en_o   (wr_en),
        .wr_addr_o (wr_addr),
        .wr_data_o (wr_data),
        .rd_req_o  (rd_req),
        .rd_addr_o (rd_addr),
        .rd_data_i (rd_data)
    );

    pin_sequencer u_seq (
        .clk_i   (REF_CLK_I),
        .rst_n_i (RST_N_I),
        .start_i (start),
        .op_i    (op),
        .chan_i  (chan),
        .phase_o (phase),
        .count_o (count),
        .done_o  (seq_done)
    );

    // Register readback; unmapped addresses read as zero
    always @* begin
        case (rd_addr)
            `REG_CTRL:        rd_data = {22'h0, variant_zero, 1'b0, 1'b0, op, 2'b00, chan};
            `REG_WDATA:       rd_data = {20'h0, wdata};
            `REG_STATUS:      rd_data = {29'h0, bad_op, done, busy};
            `REG_RDATA:       rd_data = {20'h0, rdata};
            `REG_PRESET_CODE: rd_data = {20'h0, variant_zero ? `CODE_ZERO : `CODE_MID};
            default:          rd_data = 32'h0000_0000;
        endcase
    end

    // Command intake; a go while busy is dropped, status shows busy so software can poll
    always @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            chan         <= 2'b00;
            op           <= `OP_WRITE;
            variant_zero <= 1'b0;
            wdata        <= 12'h000;
            start        <= 1'b0;
            busy         <= 1'b0;
            done         <= 1'b0;
            bad_op       <= 1'b0;
            HREADYOUT_O  <= 1'b1;
            HRESP_O      <= 1'b0;
        end else begin
            start       <= 1'b0;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            if (seq_done) begin
                busy <= 1'b0;
                done <= 1'b1;
            end
            if (wr_en && wr_addr == `REG_WDATA && !busy) begin
                wdata <= wr_data[11:0];
            end
            if (wr_en && wr_addr == `REG_STATUS) begin
                // Sequencer completion in the same cycle wins over the clear
                if (wr_data[`STAT_DONE] && !seq_done) begin
                    done <= 1'b0;
                end
                if (wr_data[`STAT_BAD_OP]) begin
                    bad_op <= 1'b0;
                end
            end
            if (wr_en && wr_addr == `REG_CTRL && !busy) begin
                chan         <= wr_data[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB];
                op           <= wr_data[`CTRL_OP_MSB:`CTRL_OP_LSB];
                variant_zero <= wr_data[`CTRL_VARIANT];
                if (wr_data[`CTRL_GO_BIT]) begin
                    if (op_valid(wr_data[`CTRL_OP_MSB:`CTRL_OP_LSB])) begin
                        start <= 1'b1;
                        busy  <= 1'b1;
                        done  <= 1'b0;
                    end else begin
                        bad_op <= 1'b1;
                    end
                end
            end
        end
    end

    // Pin driver: all pins from flip-flops, changed only between strobes
    always @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            DATA_O            <= 12'h000;
            DATA_OE_O         <= 1'b0;
            CHAN_SEL_LO_O     <= 1'b0;
            CHAN_SEL_HI_O     <= 1'b0;
            RD_WR_N_O         <= 1'b1;
            CHIP_SEL_N_O      <= 1'b1;
            OUTPUT_UPDATE_N_O <= 1'b1;
            PRESET_N_O        <= 1'b1;
            rdata             <= 12'h000;
        end else begin
            case (phase)
                PH_SETUP: begin
                    CHAN_SEL_LO_O <= chan[0];
                    CHAN_SEL_HI_O <= chan[1];
                    RD_WR_N_O     <= (op == `OP_READ);
                    DATA_O        <= wdata;
                    // Host releases the bus for reads so the device can drive it
                    DATA_OE_O     <= is_port_op(op) && (op != `OP_READ);
                    // Update strobe stays high here: low with chip select high would load all channels
                    OUTPUT_UPDATE_N_O <= 1'b1;
                end
                PH_STROBE: begin
                    if (is_port_op(op)) begin
                        CHIP_SEL_N_O <= 1'b0;
                    end
                    if (op == `OP_WRITE_THRU) begin
                        OUTPUT_UPDATE_N_O <= 1'b0;
                    end
                    if (op == `OP_UPDATE_ALL) begin
                        CHIP_SEL_N_O      <= 1'b1;
                        OUTPUT_UPDATE_N_O <= 1'b0;
                    end
                    if (op == `OP_PRESET || op == `OP_PRESET_LATCH) begin
                        PRESET_N_O <= 1'b0;
                    end
                    if (op == `OP_PRESET_LATCH) begin
                        CHIP_SEL_N_O <= 1'b1;
                    end
                end
                PH_HOLD: begin
                    if (op == `OP_READ && !CHIP_SEL_N_O) begin
                        rdata <= DATA_I;
                    end
                    OUTPUT_UPDATE_N_O <= 1'b1;
                    PRESET_N_O        <= 1'b1;
                    // Chip select rises on the same edge as the update strobe, so a transparent write never ends as a load of all channels
                    CHIP_SEL_N_O      <= 1'b1;
                end
                default: begin
                    DATA_OE_O    <= 1'b0;
                    RD_WR_N_O    <= 1'b1;
                    CHIP_SEL_N_O <= 1'b1;
                end
            endcase
        end
    end

endmodule

// File: pkg/dac_port_consts.vh
`ifndef DAC_PORT_CONSTS_VH
`define DAC_PORT_CONSTS_VH

// Own register map on the AHB-Lite slave (byte addresses)
`define REG_CTRL        12'h000
`define REG_WDATA       12'h004
`define REG_STATUS      12'h008
`define REG_RDATA       12'h00c
`define REG_PRESET_CODE 12'h010

// Control register fields
`define CTRL_CHAN_LSB   0
`define CTRL_CHAN_MSB   1
`define CTRL_OP_LSB     4
`define CTRL_OP_MSB     6
`define CTRL_GO_BIT     8
`define CTRL_VARIANT    9

// Operations
`define OP_WRITE        3'h0
`define OP_WRITE_THRU   3'h1
`define OP_READ         3'h2
`define OP_UPDATE_ALL   3'h3
`define OP_PRESET       3'h4
`define OP_PRESET_LATCH 3'h5

// Status fields
`define STAT_BUSY       0
`define STAT_DONE       1
`define STAT_BAD_OP     2

// Data bus
`define DATA_W          12
`define CHAN_NUM        4
`define CODE_MID        12'h800
`define CODE_ZERO       12'h000
`define CODE_SPAN       4096

// Timing
`define CLK_PERIOD_NS   100
`define UPDATE_PULSE_MIN_NS 10
`define UPDATE_PULSE_CYC (((`UPDATE_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                          ((`UPDATE_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define SETUP_CYC       1
`define STROBE_CYC      2

`endif

// File: design/ahb_reg_slave.v
`timescale 1ns/1ps
`include "dac_port_consts.vh"

module ahb_reg_slave (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // AHB-Lite slave
    input  wire        hsel_i,
    input  wire [11:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    output reg  [31:0] hrdata_o,
    // Register access strobes
    output reg         wr_en_o,
    output reg  [11:0] wr_addr_o,
    output wire [31:0] wr_data_o,
    output wire        rd_req_o,
    output wire [11:0] rd_addr_o,
    input  wire [31:0] rd_data_i
);

    reg        pend_wr;
    reg [11:0] pend_addr;

    // Always ready: every access completes in its first data-phase cycle
    assign rd_req_o  = hsel_i && htrans_i[1] && !hwrite_i;
    assign rd_addr_o = haddr_i;
    assign wr_data_o = hwdata_i;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_wr   <= 1'b0;
            pend_addr <= 12'h000;
            hrdata_o  <= 32'h0000_0000;
        end else begin
            pend_wr   <= hsel_i && htrans_i[1] && hwrite_i;
            pend_addr <= haddr_i;
            if (rd_req_o) begin
                hrdata_o <= rd_data_i;
            end
        end
    end

    always @* begin
        wr_en_o   = pend_wr;
        wr_addr_o = pend_addr;
    end

endmodule

// File: design/pin_sequencer.v
`timescale 1ns/1ps
`include "dac_port_consts.vh"

module pin_sequencer (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    // Command
    input  wire        start_i,
    input  wire [2:0]  op_i,
    input  wire [1:0]  chan_i,
    // Sequencer phase, cycle count and completion pulse
    output reg  [1:0]  phase_o,
    output reg  [3:0]  count_o,
    output reg         done_o
);

    localparam PH_IDLE   = 2'd0;
    localparam PH_SETUP  = 2'd1;
    localparam PH_STROBE = 2'd2;
    localparam PH_HOLD   = 2'd3;

    // Phase lengths kept as full words; only the low bits reach the counter
    localparam [31:0] SETUP_LEN  = `SETUP_CYC;
    localparam [31:0] STROBE_LEN = `STROBE_CYC;
    localparam [31:0] UPDATE_LEN = `UPDATE_PULSE_CYC;

    reg [1:0] next_phase;
    reg [3:0] next_count;

    always @* begin
        next_phase = phase_o;
        next_count = count_o;
        case (phase_o)
            PH_IDLE: begin
                if (start_i) begin
                    next_phase = PH_SETUP;
                    next_count = SETUP_LEN[3:0];
                end
            end
            PH_SETUP: begin
                if (count_o <= 4'd1) begin
                    next_phase = PH_STROBE;
                    next_count = (op_i == `OP_UPDATE_ALL) ? UPDATE_LEN[3:0] : STROBE_LEN[3:0];
                end else begin
                    next_count = count_o - 4'd1;
                end
            end
            PH_STROBE: begin
                if (count_o <= 4'd1) begin
                    next_phase = PH_HOLD;
                    next_count = 4'd1;
                end else begin
                    next_count = count_o - 4'd1;
                end
            end
            PH_HOLD: begin
                next_phase = PH_IDLE;
                next_count = 4'd0;
            end
            default: begin
                next_phase = PH_IDLE;
                next_count = 4'd0;
            end
        endcase
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_o <= PH_IDLE;
            count_o <= 4'd0;
            done_o  <= 1'b0;
        end else begin
            phase_o <= next_phase;
            count_o <= next_count;
            done_o  <= (phase_o == PH_HOLD);
        end
    end

endmodule

// File: test/dac_port_host_asserts.sv
`timescale 1ns/1ps
module dac_port_host_asserts (
    // Clock and reset
    input logic        REF_CLK_I,
    input logic        RST_N_I,
    // Bus answer and converter port
    input logic        HREADYOUT_O,
    input logic        HRESP_O,
    input logic [11:0] DATA_O,
    input logic        DATA_OE_O,
    input logic        CHAN_SEL_LO_O,
    input logic        CHAN_SEL_HI_O,
    input logic        RD_WR_N_O,
    input logic        CHIP_SEL_N_O,
    input logic        OUTPUT_UPDATE_N_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence port_strobe;
        !CHIP_SEL_N_O ##1 CHIP_SEL_N_O;
    endsequence
    sequence update_release;
        $rose(OUTPUT_UPDATE_N_O);
    endsequence
    a_bus_okay: assert property (HREADYOUT_O && !HRESP_O) else $error("bus answer not ready");
    a_strobe_len: assert property ($fell(CHIP_SEL_N_O) |-> ##1 port_strobe)
        else $error("chip select strobe length wrong");
    a_sel_steady: assert property (!CHIP_SEL_N_O |-> $stable({CHAN_SEL_HI_O, CHAN_SEL_LO_O, RD_WR_N_O}))
        else $error("select lines moved during strobe");
    a_write_data: assert property (!CHIP_SEL_N_O && !RD_WR_N_O |-> DATA_OE_O && $stable(DATA_O))
        else $error("write data not held");
    a_read_release: assert property (!CHIP_SEL_N_O && RD_WR_N_O |-> !DATA_OE_O)
        else $error("bus driven during read");
    a_oe_write: assert property (DATA_OE_O |-> !RD_WR_N_O)
        else $error("bus driven while not writing");
    a_update_pulse: assert property ($fell(OUTPUT_UPDATE_N_O) && CHIP_SEL_N_O |=> update_release)
        else $error("update strobe width wrong");
    a_update_idle: assert property ($fell(OUTPUT_UPDATE_N_O) && CHIP_SEL_N_O |-> !DATA_OE_O)
        else $error("load of all channels during a write");
    a_thru_write: assert property (!OUTPUT_UPDATE_N_O && !CHIP_SEL_N_O |-> !RD_WR_N_O && DATA_OE_O)
        else $error("transparent strobe without write");
endmodule

// File: test/dac_dev_model.sv
`timescale 1ns/1ps
module dac_dev_model #(
    parameter logic [11:0] PRESET_CODE = 12'h800
) (
    input  wire logic [11:0] bus_in,
    input  wire logic        bus_oe,
    input  wire logic [1:0]  sel,
    input  wire logic        rd_wr_n,
    input  wire logic        cs_n,
    input  wire logic        upd_n,
    input  wire logic        preset_n,
    output wire logic [11:0] bus_out
);
    logic [11:0] in_reg [4];
    logic [11:0] out_reg [4];
    logic [11:0] last = 12'h000;
    wire  [11:0] wval = bus_oe ? bus_in : ~last;
    // Level driven like the real part: no clock, every pin change is evaluated at once
    always @(bus_in or bus_oe or sel or rd_wr_n or cs_n or upd_n or preset_n) begin
        if (!preset_n) begin
            for (int i = 0; i < 4; i++) begin
                in_reg[i] = PRESET_CODE;
                out_reg[i] = PRESET_CODE;
            end
        end else if (!cs_n) begin
            if (!rd_wr_n) begin
                in_reg[sel] = wval;
                if (!upd_n) out_reg[sel] = wval;
            end
        end else if (!upd_n) begin
            for (int i = 0; i < 4; i++) out_reg[i] = in_reg[i];
        end
        if (!cs_n && rd_wr_n) last = in_reg[sel];
    end
    // Released bus shows a changed value so a stale sample cannot pass
    assign bus_out = (!cs_n && rd_wr_n) ? in_reg[sel] : ~last;
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
`include "dac_port_consts.vh"
module tb;
    logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
    logic [11:0] haddr = 0, data_o, data_i, ei [4], eo [4];
    logic [1:0]  htrans = 0;
    logic [31:0] hwdata = 0, hrdata;
    logic        hready, hresp, data_oe, sel_lo, sel_hi, rd_wr_n, cs_n, upd_n, preset_n;
    int          fail_count = 0, num_checks = 0;
    always #50 clk = ~clk;
    dac_port_host dac_port_host_i (.REF_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .DATA_O(data_o), .DATA_OE_O(data_oe), .DATA_I(data_i),
        .CHAN_SEL_LO_O(sel_lo), .CHAN_SEL_HI_O(sel_hi), .RD_WR_N_O(rd_wr_n), .CHIP_SEL_N_O(cs_n),
        .OUTPUT_UPDATE_N_O(upd_n), .PRESET_N_O(preset_n));
    dac_dev_model dac_dev_model_i (.bus_in(data_o), .bus_oe(data_oe), .sel({sel_hi, sel_lo}),
        .rd_wr_n(rd_wr_n), .cs_n(cs_n), .upd_n(upd_n), .preset_n(preset_n), .bus_out(data_i));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1; htrans <= 2'b10; haddr <= a; hwrite <= wr;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
        hsel <= 0; htrans <= 2'b00; hwdata <= wd;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 40);
        rd = hrdata;
        if (n >= 40) begin fail_count++; print_verdict(); end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic run(input logic [2:0] op, input logic [1:0] ch, input logic [11:0] d, output logic [31:0] s);
        int n;
        n = 0;
        wreg(`REG_WDATA, {20'h0, d});
        wreg(`REG_CTRL, {23'h0, 1'b1, 1'b0, op, 2'b00, ch});
        do begin ahb(1'b0, `REG_STATUS, 0, s); n++; end while (s[2:1] === 2'b00 && n < 30);
        if (n >= 30) begin fail_count++; print_verdict(); end
        wreg(`REG_STATUS, 32'h6);
    endtask
    task automatic cmp_regs();
        for (int i = 0; i < 4; i++) begin
            check("input reg", ei[i], dac_dev_model_i.in_reg[i]);
            check("output reg", eo[i], dac_dev_model_i.out_reg[i]);
        end
    endtask
    initial begin
        logic [31:0] r;
        logic [11:0] v;
        logic [1:0]  c;
        void'($urandom(32'h4babe767));
        repeat (6) @(posedge clk);
        rst_n <= 1;
        ahb(1'b0, `REG_PRESET_CODE, 0, r); check("preset code", {20'h0, `CODE_MID}, r);
        wreg(`REG_CTRL, 32'h200);
        ahb(1'b0, `REG_PRESET_CODE, 0, r); check("preset code alt", {20'h0, `CODE_ZERO}, r);
        wreg(`REG_CTRL, 32'h0);
        ahb(1'b0, 12'h020, 0, r); check("unmapped", 32'h0, r);
        run(`OP_PRESET, 2'd0, 12'h0, r);
        foreach (ei[i]) begin ei[i] = 12'h800; eo[i] = 12'h800; end
        cmp_regs();
        for (int i = 0; i < 4; i++) begin
            v = (i == 3) ? 12'hfff : 12'($urandom);
            run(`OP_WRITE, 2'(i), v, r);
            ei[i] = v;
        end
        cmp_regs();
        for (int i = 0; i < 4; i++) begin
            run(`OP_READ, 2'(i), 12'h0, r);
            ahb(1'b0, `REG_RDATA, 0, r); check("readback", {20'h0, ei[i]}, r);
        end
        run(`OP_UPDATE_ALL, 2'd0, 12'h0, r);
        foreach (eo[i]) eo[i] = ei[i];
        cmp_regs();
        v = 12'($urandom);
        c = 2'($urandom);
        // Neighbour input differs from its output, so a stray load of all channels shows up
        run(`OP_WRITE, c + 2'd1, ~v, r);
        ei[c + 2'd1] = ~v;
        run(`OP_WRITE_THRU, c, v, r);
        ei[c] = v; eo[c] = v;
        cmp_regs();
        run(3'd6, 2'd1, 12'h123, r); check("bad op flag", 1'b1, r[2]);
        cmp_regs();
        run(`OP_PRESET_LATCH, 2'd2, 12'h0, r);
        foreach (ei[i]) begin ei[i] = 12'h800; eo[i] = 12'h800; end
        cmp_regs();
        print_verdict();
    end
endmodule
bind dac_port_host dac_port_host_asserts dac_port_host_asserts_i (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
    .CHAN_SEL_LO_O(CHAN_SEL_LO_O), .CHAN_SEL_HI_O(CHAN_SEL_HI_O), .RD_WR_N_O(RD_WR_N_O),
    .CHIP_SEL_N_O(CHIP_SEL_N_O), .OUTPUT_UPDATE_N_O(OUTPUT_UPDATE_N_O));
